// ---- verilog/trts_params.svh ----
// Purpose: Named constants for the tone ringer tone select block.
// Assumes: 40 MHz system clock.
// Notes: Tone half periods are counted in clock cycles.
`ifndef TRTS_PARAMS_SVH
`define TRTS_PARAMS_SVH
`define TRTS_CLK_HZ 40000000
`define TRTS_TONE_HZ_0 1200
`define TRTS_TONE_HZ_1 940
`define TRTS_TONE_HZ_2 900
`define TRTS_TONE_HZ_3 750
// Modulation rates are held in tenths of a hertz so 7.5 Hz stays exact.
`define TRTS_RATE_DHZ_0 200
`define TRTS_RATE_DHZ_1 150
`define TRTS_RATE_DHZ_2 100
`define TRTS_RATE_DHZ_3 75
`define TRTS_CNT_W 24
`endif

// ---- verilog/trts_pkg.sv ----
// Purpose: Types for the tone ringer tone select block.
// Assumes: Nothing beyond the parameter header.
// Notes: Select pins are open (high) or low.
`default_nettype none
package trts_pkg;
    typedef enum logic [1:0] {TRTS_FSK, TRTS_AM, TRTS_OFF} trts_mode_e;
    typedef struct packed {
        logic [1:0] freq_sel;
        logic [1:0] rate_sel;
        logic am_sel_n;
        logic inhibit_n;
    } trts_sel_s;
endpackage
`default_nettype wire

// ---- verilog/trts_tone_ringer.sv ----
// Purpose: Tone and warble generator with ringing indication for a tone ringer.
// Assumes: Pins are synchronised here; ring_detected comes from the analog detector.
// Notes: Both tone and warble timing are divided from sys_clk.
// Notes on behaviour
// - Frequency selects give 1200, 940, 900 or 750 Hz base tone.
// - Rate selects give 20, 15, 10 or 7.5 Hz modulation rate.
// - Inhibit and AM open: tone alternates base and five quarters base.
// - Inhibit open, AM low: base tone gated on and off.
// - Inhibit low silences the tone whatever the AM select.
// - One modulation-type input chooses shift or on/off modulation.
// - Select pins pulled up; open reads high, low is grounded.
// - Ringing indication sinks current only while ringing is detected.
// - Alerter drive enabled only after ringing detected.
// - Frequency, rate and modulation type are independent settings.
`timescale 1ns/1ps
`default_nettype none
`include "trts_params.svh"
module trts_tone_ringer #(
    // Clock rate that the dividers are worked out from; a bench may give a slower one.
    parameter int CLK_HZ = `TRTS_CLK_HZ,
    parameter int CNT_W = `TRTS_CNT_W
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Select pins, already resolved by pull-ups to high when open.
    input wire trts_pkg::trts_sel_s sel_pins,
    // Ringing detector level.
    input wire logic ring_detected,
    // Alerter drive.
    output logic tone_out,
    output logic tone_oe,
    // Ringing indication open-collector sink.
    output logic ring_seen_sink
);
    import trts_pkg::*;

    // Half periods in clock cycles. The product CLK_HZ * 5 is an int, so clocks above
    // about 400 MHz overflow it, and CNT_W must hold the slowest warble half period.
    localparam logic [CNT_W-1:0] H0 = CNT_W'(CLK_HZ / (2 * `TRTS_TONE_HZ_0));
    localparam logic [CNT_W-1:0] H1 = CNT_W'(CLK_HZ / (2 * `TRTS_TONE_HZ_1));
    localparam logic [CNT_W-1:0] H2 = CNT_W'(CLK_HZ / (2 * `TRTS_TONE_HZ_2));
    localparam logic [CNT_W-1:0] H3 = CNT_W'(CLK_HZ / (2 * `TRTS_TONE_HZ_3));
    localparam logic [CNT_W-1:0] M0 = CNT_W'(CLK_HZ * 5 / `TRTS_RATE_DHZ_0);
    localparam logic [CNT_W-1:0] M1 = CNT_W'(CLK_HZ * 5 / `TRTS_RATE_DHZ_1);
    localparam logic [CNT_W-1:0] M2 = CNT_W'(CLK_HZ * 5 / `TRTS_RATE_DHZ_2);
    localparam logic [CNT_W-1:0] M3 = CNT_W'(CLK_HZ * 5 / `TRTS_RATE_DHZ_3);

    trts_sel_s sel_meta;
    trts_sel_s sel;
    logic ring_meta;
    logic ring;
    logic [CNT_W-1:0] tone_cnt;
    logic [CNT_W-1:0] warb_cnt;
    logic [CNT_W-1:0] base_half;
    logic [CNT_W-1:0] tone_half;
    logic [CNT_W-1:0] warb_half;
    logic warb_phase;
    logic tone_sq;
    logic active;
    trts_mode_e mode;

    // Pins arrive asynchronously, so every one passes two flip-flops first.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sel_meta <= '1;
            sel <= '1;
            ring_meta <= 1'b0;
            ring <= 1'b0;
        end
        else
        begin
            sel_meta <= sel_pins;
            sel <= sel_meta;
            ring_meta <= ring_detected;
            ring <= ring_meta;
        end
    end

    // Each select decodes on its own; no combination is excluded.
    always_comb
    begin
        unique case (sel.freq_sel)
            2'h3: base_half = H0;
            2'h2: base_half = H1;
            2'h1: base_half = H2;
            2'h0: base_half = H3;
        endcase
        unique case (sel.rate_sel)
            2'h3: warb_half = M0;
            2'h2: warb_half = M1;
            2'h1: warb_half = M2;
            2'h0: warb_half = M3;
        endcase
    end

    // Mode picks from inhibit first, then the single AM/FM select.
    always_comb
    begin
        if (!ring || !sel.inhibit_n)
            mode = TRTS_OFF;
        else if (sel.am_sel_n)
            mode = TRTS_FSK;
        else
            mode = TRTS_AM;
    end

    // Shifted tone at 5/4 f has a half period of 4/5 of the base one.
    assign tone_half = (mode == TRTS_FSK && warb_phase)
        ? CNT_W'((base_half * 4) / 5) : base_half;

    assign active = (mode != TRTS_OFF);

    // Warble divider; held cleared while silent so each ring starts alike.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            warb_cnt <= '0;
            warb_phase <= 1'b0;
        end
        else if (!active)
        begin
            warb_cnt <= '0;
            warb_phase <= 1'b0;
        end
        else if (warb_cnt >= warb_half - CNT_W'(1))
        begin
            warb_cnt <= '0;
            warb_phase <= ~warb_phase;
        end
        else
            warb_cnt <= warb_cnt + CNT_W'(1);
    end

    // Tone divider from the same clock.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tone_cnt <= '0;
            tone_sq <= 1'b0;
        end
        else if (!active)
        begin
            tone_cnt <= '0;
            tone_sq <= 1'b0;
        end
        else if (tone_cnt >= tone_half - CNT_W'(1))
        begin
            tone_cnt <= '0;
            tone_sq <= ~tone_sq;
        end
        else
            tone_cnt <= tone_cnt + CNT_W'(1);
    end

    // Registered outputs; AM gates the tone during the off half of the warble.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tone_out <= 1'b0;
            tone_oe <= 1'b0;
            ring_seen_sink <= 1'b0;
        end
        else
        begin
            // Gating by active too keeps a high half cycle from leaking past a stop.
            tone_out <= active && tone_sq && !(mode == TRTS_AM && warb_phase);
            tone_oe <= active;
            ring_seen_sink <= ring;
        end
    end

    // Output and divider checks, all on sys_clk and idle while reset is held.
    a_inhibit_silent: assert property (@(posedge sys_clk) disable iff (rst)
        !sel.inhibit_n |=> !tone_out && !tone_oe)
        else $error("tone present while inhibited");
    a_ring_sink: assert property (@(posedge sys_clk) disable iff (rst)
        ring_seen_sink == $past(ring))
        else $error("ring indication does not follow detector");
    a_no_ring_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !ring |=> !tone_oe)
        else $error("alerter driven without ringing");
    a_idle_counters: assert property (@(posedge sys_clk) disable iff (rst)
        !active |=> tone_cnt == '0 && warb_cnt == '0)
        else $error("dividers run while silent");
    a_am_gated: assert property (@(posedge sys_clk) disable iff (rst)
        (mode == TRTS_AM && warb_phase) |=> !tone_out)
        else $error("AM tone present in off phase");
    a_fsk_shift: assert property (@(posedge sys_clk) disable iff (rst)
        (mode == TRTS_FSK && warb_phase) |-> tone_half < base_half)
        else $error("shifted tone not higher");
    // A select change may leave a count above the new limit for the one cycle it takes to wrap.
    a_tone_bound: assert property (@(posedge sys_clk) disable iff (rst)
        $stable(tone_half) |-> tone_cnt < tone_half)
        else $error("tone divider overran");
    a_warb_bound: assert property (@(posedge sys_clk) disable iff (rst)
        $stable(warb_half) |-> warb_cnt < warb_half)
        else $error("warble divider overran");

    // Checks that tie the outputs, tone half period and warble phase to the synchronised pins, and the synchroniser stages together.
    a_oe_follows_ring: assert property (@(posedge sys_clk) disable iff (rst)
        tone_oe == $past(ring && sel.inhibit_n))
        else $error("alerter drive does not follow ringing and inhibit");
    a_off_silent: assert property (@(posedge sys_clk) disable iff (rst)
        !active |=> !tone_out)
        else $error("tone present while silent");
    a_am_base_tone: assert property (@(posedge sys_clk) disable iff (rst)
        mode == TRTS_AM |-> tone_half == base_half)
        else $error("AM tone not at base frequency");
    a_fsk_base_phase: assert property (@(posedge sys_clk) disable iff (rst)
        (mode == TRTS_FSK && !warb_phase) |-> tone_half == base_half)
        else $error("FSK first phase not at base frequency");
    a_phase_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !active |=> !warb_phase)
        else $error("warble phase left set while silent");
    a_sel_sync: assert property (@(posedge sys_clk) disable iff (rst)
        sel == $past(sel_meta))
        else $error("select synchroniser skipped a stage");
endmodule
`default_nettype wire

// ---- dv/trts_pin_model.sv ----
// Purpose: Switch bank on the select pins, with the pull-ups of each pin.
// Assumes: A set bit of to_common closes that pin's switch to common.
// Notes: Bit order follows trts_sel_s, freq_sel down to inhibit_n.
`timescale 1ns/1ps
`default_nettype none
module trts_pin_model (
    // Switch closures.
    input wire logic [5:0] to_common,
    // Resolved pin levels.
    output trts_pkg::trts_sel_s sel_pins
);
    import trts_pkg::*;
    // An open switch leaves the pull-up in charge, so the pin reads high.
    assign sel_pins = trts_sel_s'(~to_common);
endmodule
`default_nettype wire

// ---- dv/trts_tone_ringer_bench.sv ----
// Purpose: Self-checking bench for the tone ringer tone select block.
// Assumes: 40 MHz clock; the block is told a slow clock so whole warble phases fit the run.
// Notes: Half periods are checked within two cycles; warble rates within one tone period.
`timescale 1ns/1ps
`default_nettype none
`include "trts_params.svh"
module trts_tone_ringer_bench;
    import trts_pkg::*;
    // Clock rate the block is told; 200 times slower keeps every warble half period short.
    localparam int CLK = 200000;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ring = 1'b0;
    logic [5:0] gnd = 6'h00;
    trts_sel_s sel_pins;
    logic tone_out, tone_oe, ring_seen_sink;
    int failures = 0;
    int total_checks = 0;
    trts_pin_model trts_pin_model_inst (.to_common(gnd), .sel_pins(sel_pins));
    trts_tone_ringer #(.CLK_HZ(CLK)) trts_tone_ringer_inst (.sys_clk(sys_clk), .rst(rst),
        .sel_pins(sel_pins), .ring_detected(ring), .tone_out(tone_out),
        .tone_oe(tone_oe), .ring_seen_sink(ring_seen_sink));
    // Clock at 25 ns.
    initial forever #12.5 sys_clk = ~sys_clk;
    // Compare one observed bit with its expected value.
    task automatic chk(input string name, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %b seen %b", name, exp, seen);
        end
    endtask
    // Apply pins at the falling edge, then let the pipeline settle.
    task automatic apply(input logic r, input logic [5:0] g, input int n);
        @(negedge sys_clk);
        ring = r;
        gnd = g;
        repeat (n) @(negedge sys_clk);
    endtask
    // Silent when idle, sink and drive follow ringing, inhibit mutes.
    task automatic t_levels();
        chk("oe_idle", tone_oe, 1'b0);
        chk("sink_idle", ring_seen_sink, 1'b0);
        apply(1'b1, 6'h00, 4);
        chk("sink_on", ring_seen_sink, 1'b1);
        chk("oe_on", tone_oe, 1'b1);
        apply(1'b1, 6'h01, 4);
        chk("tone_inh", tone_out, 1'b0);
        chk("oe_inh", tone_oe, 1'b0);
        apply(1'b1, 6'h03, 4);
        chk("tone_inh_am", tone_out, 1'b0);
        apply(1'b0, 6'h00, 4);
        chk("tone_off", tone_out, 1'b0);
        chk("sink_off", ring_seen_sink, 1'b0);
        $display("test levels done");
    endtask
    // First tone half period after activation for one frequency code.
    task automatic t_freq(input logic [1:0] code, input int half);
        int cnt;
        cnt = 0;
        apply(1'b0, {code, 4'h0}, 4);
        apply(1'b1, {code, 4'h0}, 0);
        while (tone_oe !== 1'b1 && cnt < 10)
        begin
            @(negedge sys_clk);
            cnt++;
        end
        cnt = 0;
        while (tone_out !== 1'b1 && cnt < half + 10)
        begin
            @(negedge sys_clk);
            cnt++;
        end
        chk("half_period", logic'(cnt >= half - 2 && cnt <= half + 2), 1'b1);
        $display("test freq %0d done, %0d cycles", code, cnt);
    endtask
    // Cycles from one rising edge of the tone to the next, bounded so a dead tone ends it.
    task automatic rise_gap(output int gap);
        int n;
        n = 0;
        while (tone_out !== 1'b0 && n < 1000)
        begin
            @(negedge sys_clk);
            n++;
        end
        while (tone_out !== 1'b1 && n < 1000)
        begin
            @(negedge sys_clk);
            n++;
        end
        gap = 0;
        while (tone_out !== 1'b0 && gap < 1000)
        begin
            @(negedge sys_clk);
            gap++;
        end
        while (tone_out !== 1'b1 && gap < 1000)
        begin
            @(negedge sys_clk);
            gap++;
        end
    endtask
    // AM: tone present before the warble phase turns, silent for a tone period after it.
    task automatic t_am(input logic [1:0] fcode, input logic [1:0] rcode, input int half,
        input int warb);
        int c;
        int highs_on;
        int highs_off;
        c = 0;
        highs_on = 0;
        highs_off = 0;
        apply(1'b0, {fcode, rcode, 2'h2}, 4);
        apply(1'b1, {fcode, rcode, 2'h2}, 3);
        while (c < warb + 2 * half)
        begin
            if (c >= warb - 2 * half && c < warb && tone_out === 1'b1)
                highs_on++;
            if (c >= warb && tone_out !== 1'b0)
                highs_off++;
            @(negedge sys_clk);
            c++;
        end
        chk("am_on", logic'(highs_on > 0), 1'b1);
        chk("am_off", logic'(highs_off == 0), 1'b1);
        chk("am_oe", tone_oe, 1'b1);
        $display("test am rate %0d done", rcode);
    endtask
    // FSK: tone period at the base first, then at five quarters of the frequency.
    task automatic t_fsk(input logic [1:0] fcode, input logic [1:0] rcode, input int half,
        input int shifted, input int warb);
        int gap;
        apply(1'b0, {fcode, rcode, 2'h0}, 4);
        apply(1'b1, {fcode, rcode, 2'h0}, 3);
        rise_gap(gap);
        chk("fsk_base", logic'(gap >= 2 * half - 2 && gap <= 2 * half + 2), 1'b1);
        repeat (warb - half) @(negedge sys_clk);
        rise_gap(gap);
        chk("fsk_shift", logic'(gap >= 2 * shifted - 4 && gap <= 2 * shifted + 4), 1'b1);
        chk("fsk_oe", tone_oe, 1'b1);
        $display("test fsk done, shifted period %0d cycles", gap);
    endtask
    // Report counts and verdict, then stop.
    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog: the tests take about 42,000 cycles, so 60,000 can only mean a hang.
    initial
    begin
        repeat (60000) @(posedge sys_clk);
        failures++;
        end_sim();
    end
    // Main sequence.
    initial
    begin
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        t_levels();
        t_freq(2'h0, CLK / (2 * `TRTS_TONE_HZ_0));
        t_freq(2'h1, CLK / (2 * `TRTS_TONE_HZ_1));
        t_freq(2'h2, CLK / (2 * `TRTS_TONE_HZ_2));
        t_freq(2'h3, CLK / (2 * `TRTS_TONE_HZ_3));
        t_am(2'h3, 2'h0, CLK / (2 * `TRTS_TONE_HZ_3), CLK * 5 / `TRTS_RATE_DHZ_0);
        t_am(2'h2, 2'h1, CLK / (2 * `TRTS_TONE_HZ_2), CLK * 5 / `TRTS_RATE_DHZ_1);
        t_am(2'h1, 2'h2, CLK / (2 * `TRTS_TONE_HZ_1), CLK * 5 / `TRTS_RATE_DHZ_2);
        t_am(2'h0, 2'h3, CLK / (2 * `TRTS_TONE_HZ_0), CLK * 5 / `TRTS_RATE_DHZ_3);
        t_fsk(2'h0, 2'h0, CLK / (2 * `TRTS_TONE_HZ_0), CLK * 2 / (5 * `TRTS_TONE_HZ_0),
            CLK * 5 / `TRTS_RATE_DHZ_0);
        end_sim();
    end
endmodule
`default_nettype wire
